// ==== drp_pkg.sv ====
package drp_pkg;

  // Register byte addresses, one aligned 32-bit word each
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CMD     = 8'h04;
  localparam logic [7:0] ADDR_INSEL   = 8'h08;
  localparam logic [7:0] ADDR_OUTSEL  = 8'h0C;
  localparam logic [7:0] ADDR_POSVAL  = 8'h10;
  localparam logic [7:0] ADDR_STALM   = 8'h14;
  localparam logic [7:0] ADDR_CMDPOS  = 8'h18;
  localparam logic [7:0] ADDR_FBPOS   = 8'h1C;
  localparam logic [7:0] ADDR_ENC     = 8'h20;
  localparam logic [7:0] ADDR_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_MASK    = 8'h28;
  localparam logic [7:0] ADDR_SCALE   = 8'h2C;
  localparam logic [7:0] ADDR_LIMITS  = 8'h30;

  // Control register bits
  localparam int CTRL_CURRENT = 0;
  localparam int CTRL_SOFT_LIMIT = 1;
  localparam int CTRL_HOME    = 2;
  // Command register bits
  localparam int CMD_READ     = 0;
  localparam int CMD_SYNC     = 1;
  // Status / mask bits
  localparam int ST_DONE      = 0;
  localparam int ST_REJECT    = 1;
  localparam int ST_TIMEOUT   = 2;
  localparam int ST_HOMED     = 3;
  localparam int ST_W         = 4;

  // Selection field layout and ranges
  localparam int SEL_IN_W     = 3;
  localparam int SEL_OUT_W    = 4;
  localparam int N_IN_PORTS   = 5;
  localparam int N_OUT_PORTS  = 8;
  localparam logic [2:0] IN_SEL_MAX  = 3'h5;
  localparam logic [3:0] OUT_SEL_MAX = 4'h8;
  localparam logic [2:0] IN_SEL_RST  = 3'h0;
  localparam logic [3:0] OUT_SEL_RST = 4'h0;

  // Frame: 32-bit position, 8-bit status, 8-bit alarm, two bits a strobe
  localparam int POS_W        = 32;
  localparam int CODE_W       = 8;
  localparam int FRAME_W      = POS_W + 2 * CODE_W;
  localparam int EXCHANGES    = FRAME_W / 2;

  // Reset values
  localparam logic [31:0] SCALE_RST  = 32'h0000_0001;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // Timing
  localparam int CLK_MHZ          = 250;
  localparam int STROBE_HALF_NS   = 1000;
  localparam int STROBE_HALF_CYC  = (STROBE_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int READY_TMO_US     = 10000;
  localparam int READY_TMO_CYC    = READY_TMO_US * CLK_MHZ;
  localparam int HOME_PULSE_US    = 1000;
  localparam int HOME_PULSE_CYC   = HOME_PULSE_US * CLK_MHZ;

  typedef struct packed {
    logic [SEL_IN_W-1:0] bit_one;
    logic [SEL_IN_W-1:0] bit_zero;
    logic [SEL_IN_W-1:0] ready;
  } in_sel_t;

  typedef struct packed {
    logic [SEL_OUT_W-1:0] home;
    logic [SEL_OUT_W-1:0] demand;
    logic [SEL_OUT_W-1:0] strobe;
  } out_sel_t;

  typedef struct packed {
    logic home;
    logic demand;
    logic strobe;
  } link_out_t;

  typedef struct packed {
    logic bit_one;
    logic bit_zero;
    logic ready;
  } link_in_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEMAND = 3'b001,
    ST_STB_HI = 3'b010,
    ST_STB_LO = 3'b011,
    ST_FINISH = 3'b100
  } xfer_state_t;

endpackage

// ==== sync2.sv ====
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // Two stages; only the second stage is visible outside
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// ==== port_map.sv ====
`timescale 1ns/10ps
module port_map (
  input  wire logic                                 mclk,
  input  wire logic                                 rst,
  input  wire logic [drp_pkg::N_IN_PORTS-1:0]       in_pins_sync,
  input  wire drp_pkg::in_sel_t                     in_sel,
  input  wire drp_pkg::out_sel_t                    out_sel,
  input  wire drp_pkg::link_out_t                   link_out,
  output drp_pkg::link_in_t                         link_in,
  output logic [drp_pkg::N_OUT_PORTS-1:0]           out_pins
);

  // Selection 0 reads as low; port n is pin index n-1
  function automatic logic pick(input logic [drp_pkg::N_IN_PORTS-1:0] pins,
                                input logic [drp_pkg::SEL_IN_W-1:0]   sel);
    pick = (sel == drp_pkg::IN_SEL_RST) ? 1'b0 : pins[sel - 3'h1];
  endfunction

  assign link_in.ready    = pick(in_pins_sync, in_sel.ready);
  assign link_in.bit_zero = pick(in_pins_sync, in_sel.bit_zero);
  assign link_in.bit_one  = pick(in_pins_sync, in_sel.bit_one);

  logic [drp_pkg::N_OUT_PORTS-1:0] nxt_out;

  // Unassigned link outputs touch no pin; several may share one port
  always_comb begin
    nxt_out = '0;
    for (int i = 0; i < drp_pkg::N_OUT_PORTS; i++) begin
      if (out_sel.strobe == 4'(i + 1)) nxt_out[i] = nxt_out[i] | link_out.strobe;
      if (out_sel.demand == 4'(i + 1)) nxt_out[i] = nxt_out[i] | link_out.demand;
      if (out_sel.home   == 4'(i + 1)) nxt_out[i] = nxt_out[i] | link_out.home;
    end
  end

  // Pins come from flip-flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) out_pins <= '0;
    else     out_pins <= nxt_out;
  end

endmodule

// ==== drive_position_readback.sv ====
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module drive_position_readback #(
  parameter int READY_TMO_CYC  = drp_pkg::READY_TMO_CYC,
  parameter int HOME_PULSE_CYC = drp_pkg::HOME_PULSE_CYC
) (
  input  wire logic                               mclk,
  input  wire logic                               rst,
  input  wire logic [7:0]                         reg_addr,
  input  wire logic [31:0]                        reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [31:0]                        reg_rdata,
  input  wire logic [drp_pkg::N_IN_PORTS-1:0]     gen_in,
  output logic      [drp_pkg::N_OUT_PORTS-1:0]    gen_out,
  input  wire logic                               pulse_busy,
  input  wire logic [15:0]                        torque_req,
  output logic      [15:0]                        torque_cmd,
  output logic                                    irq
);

  localparam int TMO_W  = $clog2(READY_TMO_CYC + 1);
  localparam int HOME_W = $clog2(HOME_PULSE_CYC + 1);
  localparam int HALF_W = $clog2(drp_pkg::STROBE_HALF_CYC + 1);
  localparam int XCH_W  = $clog2(drp_pkg::EXCHANGES + 1);

  // Software registers
  logic [1:0]               ctrl_ff;
  drp_pkg::in_sel_t         in_sel_ff;
  drp_pkg::out_sel_t        out_sel_ff;
  logic [31:0]              pos_val_ff;
  logic [15:0]              state_alarm_ff;
  logic [31:0]              cmd_pos_ff;
  logic [31:0]              fb_pos_ff;
  logic [31:0]              enc_ff;
  logic [drp_pkg::ST_W-1:0] status_ff;
  logic [drp_pkg::ST_W-1:0] mask_ff;
  logic [31:0]              scale_ff;
  logic [2:0]               limits_ff;
  logic [31:0]              rdata_ff;

  // Transfer engine
  drp_pkg::xfer_state_t         state_ff;
  drp_pkg::xfer_state_t         nxt_state;
  logic [drp_pkg::FRAME_W-1:0]  frame_ff;
  logic [XCH_W-1:0]             xch_ff;
  logic [HALF_W-1:0]            half_ff;
  logic [TMO_W-1:0]             tmo_ff;
  logic                         sync_mode_ff;
  logic [HOME_W-1:0]            home_cnt_ff;

  // Pins in, through two flops, then the selection map
  logic [drp_pkg::N_IN_PORTS-1:0] pins_sync;
  drp_pkg::link_in_t              link_in;
  drp_pkg::link_out_t             link_out;

  sync2 #(
    .WIDTH (drp_pkg::N_IN_PORTS)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (gen_in),
    .sync_out (pins_sync)
  );

  port_map u_map (
    .mclk         (mclk),
    .rst          (rst),
    .in_pins_sync (pins_sync),
    .in_sel       (in_sel_ff),
    .out_sel      (out_sel_ff),
    .link_out     (link_out),
    .link_in      (link_in),
    .out_pins     (gen_out)
  );

  // Bus decode
  wire wr_ctrl   = reg_wr && (reg_addr == drp_pkg::ADDR_CTRL);
  wire wr_cmd    = reg_wr && (reg_addr == drp_pkg::ADDR_CMD);
  wire wr_insel  = reg_wr && (reg_addr == drp_pkg::ADDR_INSEL);
  wire wr_outsel = reg_wr && (reg_addr == drp_pkg::ADDR_OUTSEL);
  wire wr_cmdpos = reg_wr && (reg_addr == drp_pkg::ADDR_CMDPOS);
  wire wr_fbpos  = reg_wr && (reg_addr == drp_pkg::ADDR_FBPOS);
  wire wr_enc    = reg_wr && (reg_addr == drp_pkg::ADDR_ENC);
  wire wr_status = reg_wr && (reg_addr == drp_pkg::ADDR_STATUS);
  wire wr_mask   = reg_wr && (reg_addr == drp_pkg::ADDR_MASK);
  wire wr_scale  = reg_wr && (reg_addr == drp_pkg::ADDR_SCALE);

  wire current_on    = ctrl_ff[drp_pkg::CTRL_CURRENT];
  wire soft_limit_on = ctrl_ff[drp_pkg::CTRL_SOFT_LIMIT];

  // Selection writes with any field out of range are dropped whole
  drp_pkg::in_sel_t  wr_in_sel;
  drp_pkg::out_sel_t wr_out_sel;
  assign wr_in_sel  = drp_pkg::in_sel_t'(reg_wdata[3*drp_pkg::SEL_IN_W-1:0]);
  assign wr_out_sel = drp_pkg::out_sel_t'(reg_wdata[3*drp_pkg::SEL_OUT_W-1:0]);
  wire in_sel_ok  = (wr_in_sel.ready    <= drp_pkg::IN_SEL_MAX) &&
                    (wr_in_sel.bit_zero <= drp_pkg::IN_SEL_MAX) &&
                    (wr_in_sel.bit_one  <= drp_pkg::IN_SEL_MAX);
  wire out_sel_ok = (wr_out_sel.strobe  <= drp_pkg::OUT_SEL_MAX) &&
                    (wr_out_sel.demand  <= drp_pkg::OUT_SEL_MAX) &&
                    (wr_out_sel.home    <= drp_pkg::OUT_SEL_MAX);

  // Command acceptance
  wire all_assigned = (in_sel_ff.ready    != drp_pkg::IN_SEL_RST) &&
                      (in_sel_ff.bit_zero != drp_pkg::IN_SEL_RST) &&
                      (in_sel_ff.bit_one  != drp_pkg::IN_SEL_RST) &&
                      (out_sel_ff.strobe  != drp_pkg::OUT_SEL_RST) &&
                      (out_sel_ff.demand  != drp_pkg::OUT_SEL_RST);
  wire idle       = (state_ff == drp_pkg::ST_IDLE);
  wire req_read   = wr_cmd && reg_wdata[drp_pkg::CMD_READ];
  wire req_sync   = wr_cmd && reg_wdata[drp_pkg::CMD_SYNC];
  wire sync_ok    = !pulse_busy;
  wire start_ok   = idle && all_assigned && (req_read || (req_sync && sync_ok));
  wire start      = (req_read || req_sync) && start_ok;
  wire reject     = (req_read || req_sync) && !start_ok;

  // Frame fields: position first, then status, then alarm, LSB first
  wire [31:0] raw_pos   = frame_ff[drp_pkg::POS_W-1:0];
  wire [7:0]  stat_code = frame_ff[drp_pkg::POS_W +: drp_pkg::CODE_W];
  wire [7:0]  alm_code  = frame_ff[drp_pkg::POS_W + drp_pkg::CODE_W +: drp_pkg::CODE_W];

  // Scaled to user units; truncated to the register width
  wire [63:0] scaled_full = $signed(raw_pos) * $signed(scale_ff);
  wire [31:0] user_pos    = scaled_full[31:0];

  // Shift that keeps commanded minus feedback unchanged
  wire [31:0] pos_shift   = user_pos - cmd_pos_ff;

  wire half_done  = (half_ff == HALF_W'(drp_pkg::STROBE_HALF_CYC - 1));
  wire last_xch   = (xch_ff == XCH_W'(drp_pkg::EXCHANGES - 1));
  wire tmo_hit    = (tmo_ff == TMO_W'(READY_TMO_CYC - 1));
  wire finishing  = (state_ff == drp_pkg::ST_FINISH);
  wire do_sync    = finishing && sync_mode_ff;

  // Transfer state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      drp_pkg::ST_IDLE:
        if (start) begin
          nxt_state = drp_pkg::ST_DEMAND;
        end
      drp_pkg::ST_DEMAND:
        if (link_in.ready) begin
          nxt_state = drp_pkg::ST_STB_HI;
        end else if (tmo_hit) begin
          nxt_state = drp_pkg::ST_IDLE;
        end
      drp_pkg::ST_STB_HI:
        if (half_done) begin
          nxt_state = drp_pkg::ST_STB_LO;
        end
      drp_pkg::ST_STB_LO:
        if (half_done) begin
          nxt_state = last_xch ? drp_pkg::ST_FINISH : drp_pkg::ST_STB_HI;
        end
      drp_pkg::ST_FINISH:
        nxt_state = drp_pkg::ST_IDLE;
      default:
        nxt_state = drp_pkg::ST_IDLE;
    endcase
  end

  // Demand held for the whole exchange, strobe high in the high phase
  assign link_out.demand = (state_ff == drp_pkg::ST_DEMAND) ||
                           (state_ff == drp_pkg::ST_STB_HI) ||
                           (state_ff == drp_pkg::ST_STB_LO);
  assign link_out.strobe = (state_ff == drp_pkg::ST_STB_HI);
  assign link_out.home   = (home_cnt_ff != '0);

  // State, phase timer and ready timeout
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= drp_pkg::ST_IDLE;
      half_ff  <= '0;
      tmo_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      half_ff  <= (nxt_state != state_ff) ? '0 : half_ff + HALF_W'(1);
      tmo_ff   <= (state_ff == drp_pkg::ST_DEMAND) ? tmo_ff + TMO_W'(1) : '0;
    end
  end

  // Both bits sampled at the end of each strobe high phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_ff     <= '0;
      xch_ff       <= '0;
      sync_mode_ff <= 1'b0;
    end else begin
      if (start) begin
        xch_ff       <= '0;
        sync_mode_ff <= req_sync && !req_read;
      end
      if (state_ff == drp_pkg::ST_STB_HI && half_done) begin
        frame_ff <= {link_in.bit_one, link_in.bit_zero,
                     frame_ff[drp_pkg::FRAME_W-1:2]};
      end
      if (state_ff == drp_pkg::ST_STB_LO && half_done) begin
        xch_ff <= xch_ff + XCH_W'(1);
      end
    end
  end

  // Results: scaled position and packed codes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pos_val_ff     <= drp_pkg::WORD_ZERO;
      state_alarm_ff <= '0;
    end else if (finishing) begin
      pos_val_ff     <= user_pos;
      state_alarm_ff <= {stat_code, alm_code};
    end
  end

  // Commanded position; follows feedback while current is off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_pos_ff <= drp_pkg::WORD_ZERO;
    end else if (do_sync) begin
      cmd_pos_ff <= user_pos;
    end else if (!current_on) begin
      cmd_pos_ff <= fb_pos_ff;
    end else if (wr_cmdpos) begin
      cmd_pos_ff <= reg_wdata;
    end
  end

  // Feedback and tally move by the same shift as commanded
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fb_pos_ff <= drp_pkg::WORD_ZERO;
      enc_ff    <= drp_pkg::WORD_ZERO;
    end else if (do_sync) begin
      fb_pos_ff <= fb_pos_ff + pos_shift;
      enc_ff    <= enc_ff + pos_shift;
    end else begin
      if (wr_fbpos) fb_pos_ff <= reg_wdata;
      if (wr_enc)   enc_ff    <= reg_wdata;
    end
  end

  // Home set and both soft limits armed by a sync
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      limits_ff <= '0;
    end else if (do_sync && soft_limit_on) begin
      limits_ff <= 3'h7;
    end
  end

  // Torque forced to zero with current off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) torque_cmd <= '0;
    else     torque_cmd <= current_on ? torque_req : 16'h0000;
  end

  // Home pulse timer; a write of the home bit restarts it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      home_cnt_ff <= '0;
    end else if (wr_ctrl && reg_wdata[drp_pkg::CTRL_HOME]) begin
      home_cnt_ff <= HOME_W'(HOME_PULSE_CYC);
    end else if (home_cnt_ff != '0) begin
      home_cnt_ff <= home_cnt_ff - HOME_W'(1);
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff    <= '0;
      in_sel_ff  <= '{drp_pkg::IN_SEL_RST, drp_pkg::IN_SEL_RST, drp_pkg::IN_SEL_RST};
      out_sel_ff <= '{drp_pkg::OUT_SEL_RST, drp_pkg::OUT_SEL_RST, drp_pkg::OUT_SEL_RST};
      mask_ff    <= '0;
      scale_ff   <= drp_pkg::SCALE_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff[drp_pkg::CTRL_CURRENT] <= reg_wdata[drp_pkg::CTRL_CURRENT];
        ctrl_ff[drp_pkg::CTRL_SOFT_LIMIT] <= reg_wdata[drp_pkg::CTRL_SOFT_LIMIT];
      end
      if (wr_insel && in_sel_ok && idle)   in_sel_ff  <= wr_in_sel;
      if (wr_outsel && out_sel_ok && idle) out_sel_ff <= wr_out_sel;
      if (wr_mask)  mask_ff  <= reg_wdata[drp_pkg::ST_W-1:0];
      if (wr_scale) scale_ff <= reg_wdata;
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  logic [drp_pkg::ST_W-1:0] ev_set;
  assign ev_set[drp_pkg::ST_DONE]    = finishing;
  assign ev_set[drp_pkg::ST_REJECT]  = reject;
  assign ev_set[drp_pkg::ST_TIMEOUT] = (state_ff == drp_pkg::ST_DEMAND) &&
                                       !link_in.ready && tmo_hit;
  assign ev_set[drp_pkg::ST_HOMED]   = do_sync && soft_limit_on;
  wire [drp_pkg::ST_W-1:0] ev_clr = wr_status ? reg_wdata[drp_pkg::ST_W-1:0] : '0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) status_ff <= '0;
    else     status_ff <= (status_ff & ~ev_clr) | ev_set;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irq <= 1'b0;
    else     irq <= |(((status_ff & ~ev_clr) | ev_set) & mask_ff);
  end

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      drp_pkg::ADDR_CTRL:   rd_mux = {29'h0, link_out.home, ctrl_ff[1:0]};
      drp_pkg::ADDR_CMD:    rd_mux = {31'h0, !idle};
      drp_pkg::ADDR_INSEL:  rd_mux = {23'h0, in_sel_ff};
      drp_pkg::ADDR_OUTSEL: rd_mux = {20'h0, out_sel_ff};
      drp_pkg::ADDR_POSVAL: rd_mux = pos_val_ff;
      drp_pkg::ADDR_STALM:  rd_mux = {16'h0, state_alarm_ff};
      drp_pkg::ADDR_CMDPOS: rd_mux = cmd_pos_ff;
      drp_pkg::ADDR_FBPOS:  rd_mux = fb_pos_ff;
      drp_pkg::ADDR_ENC:    rd_mux = enc_ff;
      drp_pkg::ADDR_STATUS: rd_mux = {28'h0, status_ff};
      drp_pkg::ADDR_MASK:   rd_mux = {28'h0, mask_ff};
      drp_pkg::ADDR_SCALE:  rd_mux = scale_ff;
      drp_pkg::ADDR_LIMITS: rd_mux = {29'h0, limits_ff};
      default:              rd_mux = drp_pkg::WORD_ZERO;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)         rdata_ff <= drp_pkg::WORD_ZERO;
    else if (reg_rd) rdata_ff <= rd_mux;
    else             rdata_ff <= drp_pkg::WORD_ZERO;
  end

  assign reg_rdata = rdata_ff;

endmodule

// ==== drp_checker_assertions.sv ====
`timescale 1ns/10ps
module drp_checker #(
  parameter int HOME_PULSE_CYC = 20
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0]  gen_out,
  input wire logic [15:0] torque_req,
  input wire logic [15:0] torque_cmd,
  input wire logic        irq
);
  logic [11:0] osel_ff;
  logic        cur_ff;
  logic [3:0]  mask_ff;
  int          hi_ff;
  int          nstb_ff;
  int          home_ff;
  // Pin views through the shadowed selections; selection zero means no pin
  wire logic [3:0] s_w  = osel_ff[3:0];
  wire logic [3:0] d_w  = osel_ff[7:4];
  wire logic [3:0] h_w  = osel_ff[11:8];
  wire logic stb_w      = s_w != 4'h0 && gen_out[s_w - 4'h1];
  wire logic dem_w      = d_w != 4'h0 && gen_out[d_w - 4'h1];
  wire logic home_w     = h_w != 4'h0 && gen_out[h_w - 4'h1];
  wire logic wr_osel_w  = reg_wr && reg_addr == drp_pkg::ADDR_OUTSEL;
  wire logic osel_ok_w  = reg_wdata[3:0] <= 4'h8 && reg_wdata[7:4] <= 4'h8
                          && reg_wdata[11:8] <= 4'h8;
  wire logic wr_ctrl_w  = reg_wr && reg_addr == drp_pkg::ADDR_CTRL;
  wire logic wr_mask_w  = reg_wr && reg_addr == drp_pkg::ADDR_MASK;
  wire logic first_w    = stb_w && hi_ff == 0;
  // Shadows and run lengths; out-of-range selection writes leave the shadow alone
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osel_ff <= 12'h000;
      cur_ff  <= 1'b0;
      mask_ff <= 4'h0;
      hi_ff   <= 0;
      nstb_ff <= 0;
      home_ff <= 0;
    end else begin
      if (wr_osel_w && osel_ok_w) osel_ff <= reg_wdata[11:0];
      if (wr_ctrl_w) cur_ff <= reg_wdata[0];
      if (wr_mask_w) mask_ff <= reg_wdata[3:0];
      hi_ff   <= stb_w ? hi_ff + 1 : 0;
      home_ff <= home_w ? home_ff + 1 : 0;
      nstb_ff <= dem_w ? nstb_ff + (first_w ? 1 : 0) : 0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  demand_cause_a: assert property ($rose(dem_w) |-> $past(reg_wr && reg_addr == drp_pkg::ADDR_CMD, 2))
    else $error("demand rose without a command");
  strobe_framed_a: assert property (stb_w |-> dem_w)
    else $error("strobe outside demand");
  strobe_width_a: assert property ($fell(stb_w) |-> hi_ff == drp_pkg::STROBE_HALF_CYC)
    else $error("strobe high phase wrong length");
  pair_count_a: assert property ($fell(dem_w) |-> nstb_ff == 0 || nstb_ff == drp_pkg::EXCHANGES)
    else $error("wrong strobe count in frame");
  home_width_a: assert property ($fell(home_w) |-> home_ff == HOME_PULSE_CYC)
    else $error("home pulse wrong length");
  torque_off_a: assert property ((!cur_ff)[*2] |-> torque_cmd == 16'h0)
    else $error("torque while current off");
  torque_on_a: assert property (cur_ff[*2] |=> torque_cmd == $past(torque_req))
    else $error("torque not passed while current on");
  irq_masked_a: assert property ((mask_ff == 4'h0)[*2] |-> !irq)
    else $error("interrupt with all events masked");
  cover property ($rose(dem_w));
  cover property ($fell(home_w));
  cover property ($rose(irq));
endmodule
bind drive_position_readback drp_checker #(.HOME_PULSE_CYC(HOME_PULSE_CYC)) drp_checker_i (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gen_out(gen_out), .torque_req(torque_req),
  .torque_cmd(torque_cmd), .irq(irq));

// ==== drive_model.sv ====
`timescale 1ns/10ps
module drive_model (
  input  wire logic        demand,
  input  wire logic        strobe,
  input  wire logic [47:0] frame,
  input  wire integer      ready_ns,
  output logic             ready,
  output logic [1:0]       bits
);
  int idx;
  initial begin
    ready = 1'b0;
    bits  = 2'b10;
    idx   = 0;
  end
  // Ready after the drive's latency, only if demand is still held
  always @(posedge demand) begin
    idx = 0;
    #(ready_ns);
    ready = demand;
  end
  // Next pair on each strobe rise, lower bit on the bit-zero line, LSB first
  always @(posedge strobe) begin
    bits = frame[2*idx+:2];
    idx  = idx + 1;
  end
  // Released lines show the inverse, so a late sample cannot pass by luck
  always @(negedge demand) begin
    ready = 1'b0;
    bits  = ~bits;
  end
endmodule

// ==== drive_position_readback_test.sv ====
`timescale 1ns/10ps
module drive_position_readback_test;
  logic        mclk, rst, reg_wr, reg_rd, pulse_busy, irq, ready;
  logic [7:0]  reg_addr, gen_out;
  logic [31:0] reg_wdata, reg_rdata, v, sc, c, f, e, p;
  logic [15:0] torque_req, torque_cmd;
  logic [1:0]  bits, noise;
  logic [47:0] frame;
  int          ready_ns, seed, fail_count, cmp_count, cyc;
  wire logic [4:0] gen_in = {ready, noise, bits};
  drive_position_readback #(.READY_TMO_CYC(200), .HOME_PULSE_CYC(20)) drive_position_readback_i (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gen_in(gen_in), .gen_out(gen_out),
    .pulse_busy(pulse_busy), .torque_req(torque_req), .torque_cmd(torque_cmd), .irq(irq));
  drive_model drive_model_i (.demand(gen_out[0]), .strobe(gen_out[7]), .frame(frame),
    .ready_ns(ready_ns), .ready(ready), .bits(bits));
  always #2 mclk = ~mclk;
  // Noise on the two unselected input pins; the hang guard
  always @(posedge mclk) begin
    noise <= 2'($random(seed));
    cyc   <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      finish_test;
    end
  end
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rchk(input string n, input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
    if (n != "") chk(n, v, x);
  endtask
  // Fresh frame, command, then poll status until an event lands
  task run(input logic [31:0] cmd, input logic busy);
    frame = 48'({$random(seed), $random(seed)});
    @(posedge mclk) pulse_busy <= busy;
    wr(drp_pkg::ADDR_STATUS, 32'hF);
    wr(drp_pkg::ADDR_CMD, cmd);
    for (int i = 0; i < 8000; i++) begin
      rchk("", drp_pkg::ADDR_STATUS, 32'h0);
      if (v[2:0] != 3'h0) break;
    end
    p = frame[31:0] * sc;
  endtask
  task finish_test;
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {mclk, reg_wr, reg_rd, pulse_busy, reg_addr, reg_wdata, torque_req} = '0;
    {fail_count, cmp_count} = '0;
    seed = 32'h9020708E;
    ready_ns = 40;
    frame = 48'h0;
    sc = 32'h1;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rchk("insel reset", drp_pkg::ADDR_INSEL, 32'h0);
    rchk("outsel reset", drp_pkg::ADDR_OUTSEL, 32'h0);
    rchk("scale reset", drp_pkg::ADDR_SCALE, 32'h1);
    run(32'h1, 1'b0);
    chk("unassigned read", v, 32'h2);
    chk("no pin driven", {24'h0, gen_out}, 32'h0);
    // Maximum port number for ready and strobe, then out-of-range writes that must be refused
    wr(drp_pkg::ADDR_INSEL, 32'h08D);
    wr(drp_pkg::ADDR_INSEL, 32'h08E);
    wr(drp_pkg::ADDR_OUTSEL, 32'h418);
    wr(drp_pkg::ADDR_OUTSEL, 32'h419);
    rchk("insel", drp_pkg::ADDR_INSEL, 32'h08D);
    rchk("outsel", drp_pkg::ADDR_OUTSEL, 32'h418);
    sc = $random(seed);
    wr(drp_pkg::ADDR_SCALE, sc);
    wr(drp_pkg::ADDR_MASK, 32'h1);
    // Current off before reading: commanded follows feedback, no torque
    f = $random(seed);
    wr(drp_pkg::ADDR_FBPOS, f);
    rchk("cmd follows fb", drp_pkg::ADDR_CMDPOS, f);
    @(posedge mclk) torque_req <= 16'($random(seed));
    repeat (3) @(negedge mclk);
    chk("torque off", {16'h0, torque_cmd}, 32'h0);
    run(32'h3, 1'b1);
    chk("read while busy", v, 32'h1);
    chk("irq done", {31'h0, irq}, 32'h1);
    rchk("position", drp_pkg::ADDR_POSVAL, p);
    rchk("state word", drp_pkg::ADDR_STALM, {16'h0, frame[39:32], frame[47:40]});
    wr(drp_pkg::ADDR_MASK, 32'h0);
    run(32'h2, 1'b1);
    chk("sync while busy", v, 32'h2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    // Current on, soft limits on, sync keeps the deviation
    wr(drp_pkg::ADDR_CTRL, 32'h3);
    c = $random(seed);
    f = $random(seed);
    e = $random(seed);
    wr(drp_pkg::ADDR_CMDPOS, c);
    wr(drp_pkg::ADDR_FBPOS, f);
    wr(drp_pkg::ADDR_ENC, e);
    chk("torque on", {16'h0, torque_cmd}, {16'h0, torque_req});
    run(32'h2, 1'b0);
    // Done and home-set events land in the same cycle
    chk("sync done", v, 32'h9);
    rchk("commanded", drp_pkg::ADDR_CMDPOS, p);
    rchk("feedback", drp_pkg::ADDR_FBPOS, f + p - c);
    rchk("tally", drp_pkg::ADDR_ENC, e + p - c);
    rchk("limits", drp_pkg::ADDR_LIMITS, 32'h7);
    rchk("sync position", drp_pkg::ADDR_POSVAL, p);
    // Drive never answers in time
    ready_ns = 2000;
    run(32'h1, 1'b0);
    chk("ready timeout", v, 32'h4);
    repeat (600) @(posedge mclk);
    // Home pulse on its selected pin, then released
    wr(drp_pkg::ADDR_CTRL, 32'h7);
    repeat (3) @(negedge mclk);
    chk("home high", {31'h0, gen_out[3]}, 32'h1);
    repeat (30) @(negedge mclk);
    chk("home low", {24'h0, gen_out}, 32'h0);
    finish_test;
  end
endmodule
